//--- hw/adcfh_top.sv
// Converter FIFO, status/control register and AHB-Lite register slave
//
// Decided for this implementation: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
// Overview of operation
// (RQ1) Alert asserts when stored count reaches threshold
// (RQ2) External timer starts conversions asynchronously
// (RQ3) Glue stalls bus using chip select and busy; code never stalls the bus, hreadyout stays 1
// (RQ4) Glue derives read/write strobes from combined strobe
// (RQ5) Address-strobe bus glue makes strobes and waits
// (RQ6) Interrupt level encoded, acknowledged via autovector; code has one irq_o level, cleared by writing 1s to ADDR_ISTAT
// (RQ7) Host programs enable and FIFO length first
// (RQ8) Host checks range flag before reading FIFO
// (RQ9) Range flag set while any held sample out-of-range
// (RQ10) Each word flags underrange and overrange separately
// (RQ11) Host may flush samples and reinitialize
// (RQ12) Start source stays at or below 100 kHz
// (RQ13) Start pulse low at least two clocks
// (RQ14) Conversion completes within 57 clock cycles
// (RQ15) Host leaves 2 us acquisition between conversions
// (RQ16) Reads during conversion stretch it; read during acquisition; code stretches only on ADDR_DATA reads with a sample held
// (RQ17) Converter clock is the processor clock
// (RQ18) Conversion begins on first edge after start rises
// (RQ19) Wait request holds until busy clears; code never drives hreadyout low and stretches the conversion instead
module adcfh_top (
  input  wire logic                     sys_clk_i,
  input  wire logic                     rst_i,
  input  wire adcfh_pkg::adcfh_ahb_req_t ahb_i,
  input  wire logic                     conversion_start_n_i,
  input  wire adcfh_pkg::adcfh_sample_t  sample_i,
  output logic                          busy_n_o,
  output logic                          fifo_level_alert_n_o,
  output logic                          fifo_range_error_flag_o,
  output logic                          irq_o,
  output adcfh_pkg::adcfh_ahb_rsp_t      ahb_o
);
  import adcfh_pkg::*;

  adcfh_state_t st;
  adcfh_state_t next_st;
  logic         acc;
  logic         pop;
  logic         push;
  logic         start_edge;
  logic         stall;
  logic         lvl_now;
  logic         lvl_next;
  logic [3:0]   thr_now;
  logic [3:0]   thr_next;
  logic [2:0]   irq_set;
  logic [2:0]   irq_clr;
  logic [31:0]  rvalue;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st    = st;
    irq_set    = 3'h0;
    irq_clr    = 3'h0;
    rvalue     = 32'h0000_0000;
    pop        = 1'b0;
    push       = 1'b0;
    acc        = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    start_edge = conversion_start_n_i && !st.start_q;
    stall      = 1'b0;
    thr_now    = (st.thr == 3'h0) ? FIFO_FULL : {1'b0, st.thr};
    lvl_now    = st.count >= thr_now;
    next_st.start_q = conversion_start_n_i;

    // Bus read: data registered in the address phase
    if (acc && !ahb_i.hwrite)
    begin
      unique case (ahb_i.haddr[7:0])
        ADDR_DATA:
        begin
          if (st.count != 4'h0)
          begin
            rvalue = {18'h0_0000, st.mem[st.rd_ptr]}; // RQ10
            pop    = 1'b1;
          end
        end
        ADDR_CTRL:
        begin
          rvalue[CTRL_THR_LSB +: 3] = st.thr;
          rvalue[CTRL_EN_BIT]       = st.alert_en;
          rvalue[STAT_EMPTY_BIT]    = st.count == 4'h0;
          rvalue[STAT_RANGE_BIT]    = st.range_flag; // RQ9
          rvalue[STAT_CNT_LSB +: 4] = st.count;
        end
        ADDR_ISTAT: rvalue[2:0] = st.istat;
        ADDR_IMASK: rvalue[2:0] = st.imask;
        default:    rvalue      = 32'h0000_0000;
      endcase
      next_st.ahb.hrdata = rvalue;
    end

    // Conversion sequencer
    stall = !st.busy_n && pop; // RQ16
    if (st.busy_n)
    begin
      if (start_edge)
      begin
        next_st.busy_n = 1'b0; // RQ18
        next_st.cnt    = 6'h00;
      end
    end
    else if (!stall)
    begin
      if (st.cnt == CONV_LAST)
      begin
        next_st.busy_n = 1'b1; // RQ14
        push           = 1'b1;
      end
      else
        next_st.cnt = st.cnt + 6'h01;
    end

    // FIFO pointers and counts
    if (pop)
    begin
      next_st.rd_ptr = st.rd_ptr + 3'h1;
      next_st.count  = next_st.count - 4'h1;
      if (st.mem[st.rd_ptr].over || st.mem[st.rd_ptr].under)
        next_st.oor_cnt = next_st.oor_cnt - 4'h1;
    end
    if (push)
    begin
      if (st.count == FIFO_FULL && !pop)
        irq_set[IRQ_OVFL] = 1'b1;
      else
      begin
        next_st.mem[st.wr_ptr] = sample_i; // RQ10
        next_st.wr_ptr = st.wr_ptr + 3'h1;
        next_st.count  = next_st.count + 4'h1;
        if (sample_i.over || sample_i.under)
        begin
          next_st.oor_cnt     = next_st.oor_cnt + 4'h1;
          irq_set[IRQ_RANGE]  = 1'b1;
        end
      end
    end

    // Bus write: applied in the data phase
    if (st.wr_pend)
    begin
      unique case (st.wr_addr)
        ADDR_CTRL:
        begin
          next_st.thr      = ahb_i.hwdata[CTRL_THR_LSB +: 3];
          next_st.alert_en = ahb_i.hwdata[CTRL_EN_BIT];
          if (ahb_i.hwdata[CTRL_FLUSH_BIT])
          begin
            next_st.wr_ptr  = 3'h0;
            next_st.rd_ptr  = 3'h0;
            next_st.count   = 4'h0;
            next_st.oor_cnt = 4'h0;
          end
        end
        ADDR_ISTAT: irq_clr       = ahb_i.hwdata[2:0];
        ADDR_IMASK: next_st.imask = ahb_i.hwdata[2:0];
        default:    irq_clr       = 3'h0;
      endcase
    end
    next_st.wr_pend = acc && ahb_i.hwrite;
    next_st.wr_addr = ahb_i.haddr[7:0];

    // Flags, alert and interrupt
    thr_next = (next_st.thr == 3'h0) ? FIFO_FULL : {1'b0, next_st.thr};
    lvl_next = next_st.count >= thr_next;
    irq_set[IRQ_LEVEL] = lvl_next && !lvl_now;
    next_st.range_flag = next_st.oor_cnt != 4'h0; // RQ9
    next_st.alert_n    = !(next_st.alert_en && lvl_next); // RQ1
    next_st.istat      = (st.istat & ~irq_clr) | irq_set;
    next_st.irq        = |(next_st.istat & next_st.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      st               <= '0;
      st.thr           <= CTRL_THR_RST;
      st.istat         <= IRQ_RST;
      st.imask         <= IRQ_RST;
      st.alert_n       <= 1'b1;
      st.start_q       <= 1'b1;
      st.busy_n        <= 1'b1;
      st.ahb.hreadyout <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign busy_n_o                = st.busy_n;
  assign fifo_level_alert_n_o    = st.alert_n;
  assign fifo_range_error_flag_o = st.range_flag;
  assign irq_o                   = st.irq;
  assign ahb_o                   = st.ahb;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_start_seen;
    st.busy_n && conversion_start_n_i && !st.start_q;
  endsequence

  sequence s_last_step;
    !st.busy_n && st.cnt == CONV_LAST && !pop;
  endsequence

  property p_alert;
    st.alert_en && st.count >= thr_now |-> !fifo_level_alert_n_o;
  endproperty
  a_alert: assert property (p_alert) // RQ1
    else $error("alert not asserted at threshold");

  property p_range;
    push && !pop && st.count != FIFO_FULL && (sample_i.over || sample_i.under)
      && !(st.wr_pend && st.wr_addr == ADDR_CTRL
           && ahb_i.hwdata[CTRL_FLUSH_BIT])
      |=> fifo_range_error_flag_o && st.oor_cnt == $past(st.oor_cnt) + 4'h1;
  endproperty
  a_range: assert property (p_range) // RQ9
    else $error("range flag missed out-of-range sample");

  property p_word_flags;
    acc && !ahb_i.hwrite && ahb_i.haddr[7:0] == ADDR_DATA && st.count != 4'h0
      |=> ahb_o.hrdata[DATA_OVER_BIT:DATA_UNDER_BIT] ==
          {$past(st.mem[st.rd_ptr].over), $past(st.mem[st.rd_ptr].under)};
  endproperty
  a_word_flags: assert property (p_word_flags) // RQ10
    else $error("word range flags lost");

  property p_conv_len;
    s_start_seen ##1 (!pop)[*8] |-> !busy_n_o && st.cnt == 6'h07;
  endproperty
  a_conv_len: assert property (p_conv_len) // RQ14
    else $error("conversion counter off");

  property p_conv_end;
    s_last_step |=> busy_n_o && st.cnt == CONV_LAST;
  endproperty
  a_conv_end: assert property (p_conv_end) // RQ14
    else $error("conversion not ended at last cycle");

  property p_stretch;
    !st.busy_n && pop |=> !busy_n_o && $stable(st.cnt);
  endproperty
  a_stretch: assert property (p_stretch) // RQ16
    else $error("read did not stretch conversion");

  property p_begin;
    s_start_seen |=> !busy_n_o && st.cnt == 6'h00;
  endproperty
  a_begin: assert property (p_begin) // RQ18
    else $error("conversion did not begin on start edge");

endmodule : adcfh_top

//--- hw/adcfh_pkg.sv
// Shared constants and types for the sampling converter FIFO host port
package adcfh_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA  = 8'h00;
  localparam logic [7:0] ADDR_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_ISTAT = 8'h08;
  localparam logic [7:0] ADDR_IMASK = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_THR_LSB   = 0;
  localparam int CTRL_EN_BIT    = 3;
  localparam int STAT_EMPTY_BIT = 4;
  localparam int STAT_RANGE_BIT = 5;
  localparam int CTRL_FLUSH_BIT = 6;
  localparam int STAT_CNT_LSB   = 8;
  localparam int DATA_UNDER_BIT = 12;
  localparam int DATA_OVER_BIT  = 13;
  localparam int IRQ_LEVEL      = 0;
  localparam int IRQ_RANGE      = 1;
  localparam int IRQ_OVFL       = 2;

  // ----------------------------------------------------------------
  // Sizes, counts and reset values
  // ----------------------------------------------------------------
  localparam int         FIFO_DEPTH  = 8;
  localparam logic [3:0] FIFO_FULL   = 4'h8;
  localparam int         CONV_CYCLES = 56;
  localparam logic [5:0] CONV_LAST   = 6'(CONV_CYCLES - 1);
  localparam logic [2:0] CTRL_THR_RST = 3'h0;
  localparam logic [2:0] IRQ_RST      = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        over;
    logic        under;
    logic [11:0] code;
  } adcfh_sample_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } adcfh_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } adcfh_ahb_rsp_t;

  typedef struct packed {
    adcfh_sample_t [FIFO_DEPTH-1:0] mem;
    logic [2:0]     wr_ptr;
    logic [2:0]     rd_ptr;
    logic [3:0]     count;
    logic [3:0]     oor_cnt;
    logic           range_flag;
    logic [2:0]     thr;
    logic           alert_en;
    logic           alert_n;
    logic [2:0]     istat;
    logic [2:0]     imask;
    logic           irq;
    logic           start_q;
    logic           busy_n;
    logic [5:0]     cnt;
    logic           wr_pend;
    logic [7:0]     wr_addr;
    adcfh_ahb_rsp_t ahb;
  } adcfh_state_t;

endpackage : adcfh_pkg

//--- sim/adcfh_conv_src.sv
// Conversion timer and sample source model for the converter FIFO port
`timescale 1ns/1ps
module adcfh_conv_src
  import adcfh_pkg::*;
(
  input  wire logic          sys_clk_i,
  input  wire logic          busy_n_i,
  output logic               conversion_start_n_o,
  output adcfh_sample_t      sample_o
);
  initial
  begin
    conversion_start_n_o = 1'b0;
    sample_o             = '0;
  end

  // One conversion, free of the host bus; returns busy-low cycle count
  task automatic convert(input adcfh_sample_t s, output int n);
    @(posedge sys_clk_i);
    conversion_start_n_o <= 1'b0;
    sample_o             <= s;
    repeat (2) @(posedge sys_clk_i);
    conversion_start_n_o <= 1'b1;
    @(posedge sys_clk_i);
    n = 0;
    @(posedge sys_clk_i);
    while (busy_n_i !== 1'b1 && n < 200)
    begin
      n++;
      @(posedge sys_clk_i);
    end
    sample_o <= ~s;
    repeat (140) @(posedge sys_clk_i);
  endtask : convert
endmodule : adcfh_conv_src

//--- sim/adc_fifo_host_interface_test.sv
// Self-checking bench for the converter FIFO host port
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module adc_fifo_host_interface_test;
  import adcfh_pkg::*;
  logic           sys_clk_i = 1'b0;
  logic           rst_i     = 1'b1;
  adcfh_ahb_req_t req       = '0;
  adcfh_ahb_req_t ahb_req;
  adcfh_ahb_rsp_t rsp;
  logic           start_n;
  adcfh_sample_t  sample;
  logic           busy_n;
  logic           alert_n;
  logic           range_flag;
  logic           irq;
  int             bad_count    = 0;
  int             total_checks = 0;
  int             cycles       = 0;
  logic [31:0]    d;
  int             n;

  always #25 sys_clk_i = ~sys_clk_i;

  always_comb
  begin
    ahb_req        = req;
    ahb_req.hready = rsp.hreadyout;
  end

  adcfh_top i_dut (
    .sys_clk_i               (sys_clk_i),
    .rst_i                   (rst_i),
    .ahb_i                   (ahb_req),
    .conversion_start_n_i    (start_n),
    .sample_i                (sample),
    .busy_n_o                (busy_n),
    .fifo_level_alert_n_o    (alert_n),
    .fifo_range_error_flag_o (range_flag),
    .irq_o                   (irq),
    .ahb_o                   (rsp)
  );

  adcfh_conv_src i_src (
    .sys_clk_i            (sys_clk_i),
    .busy_n_i             (busy_n),
    .conversion_start_n_o (start_n),
    .sample_o             (sample)
  );

  task automatic ahb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk_i);
    req.hsel   <= 1'b1;
    req.haddr  <= {24'h00_0000, a};
    req.htrans <= 2'b10;
    req.hwrite <= w;
    req.hsize  <= 3'b010;
    @(posedge sys_clk_i);
    while (rsp.hreadyout !== 1'b1) @(posedge sys_clk_i);
    req.hsel   <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= wd;
    @(posedge sys_clk_i);
    while (rsp.hreadyout !== 1'b1) @(posedge sys_clk_i);
    rd = rsp.hrdata;
  endtask : ahb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ahb_xfer(1'b1, a, v, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb_xfer(1'b0, a, 32'h0000_0000, d);
    `CHK(d, e)
    `CHK(rsp.hresp, 1'b0)
  endtask : rd_chk

  task automatic t_reset;
    rd_chk(ADDR_CTRL, 32'h0000_0010);
    rd_chk(ADDR_ISTAT, 32'h0000_0000);
    rd_chk(ADDR_DATA, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
    `CHK(alert_n, 1'b1)
    $display("test reset done");
  endtask : t_reset

  task automatic t_level;
    wr(ADDR_CTRL, 32'h0000_000A);
    wr(ADDR_IMASK, 32'h0000_0001);
    i_src.convert({1'b0, 1'b0, 12'h123}, n);
    `CHK(n, CONV_CYCLES)
    `CHK(alert_n, 1'b1)
    rd_chk(ADDR_CTRL, 32'h0000_010A);
    i_src.convert({1'b0, 1'b0, 12'h456}, n);
    `CHK(alert_n, 1'b0)
    `CHK(irq, 1'b1)
    rd_chk(ADDR_ISTAT, 32'h0000_0001);
    wr(ADDR_ISTAT, 32'h0000_0001);
    @(posedge sys_clk_i);
    `CHK(irq, 1'b0)
    rd_chk(ADDR_DATA, 32'h0000_0123);
    rd_chk(ADDR_DATA, 32'h0000_0456);
    `CHK(alert_n, 1'b1)
    $display("test level done");
  endtask : t_level

  task automatic t_range;
    i_src.convert({1'b1, 1'b0, 12'h7FF}, n);
    `CHK(range_flag, 1'b1)
    rd_chk(ADDR_CTRL, 32'h0000_012A);
    rd_chk(ADDR_ISTAT, 32'h0000_0002);
    i_src.convert({1'b0, 1'b1, 12'h800}, n);
    rd_chk(ADDR_DATA, 32'h0000_27FF);
    `CHK(range_flag, 1'b1)
    rd_chk(ADDR_DATA, 32'h0000_1800);
    `CHK(range_flag, 1'b0)
    $display("test range done");
  endtask : t_range

  task automatic t_full;
    wr(ADDR_ISTAT, 32'h0000_0007);
    wr(ADDR_IMASK, 32'h0000_0004);
    wr(ADDR_CTRL, 32'h0000_0008);
    repeat (8) i_src.convert({1'b0, 1'b0, 12'h055}, n);
    `CHK(alert_n, 1'b0)
    `CHK(irq, 1'b0)
    rd_chk(ADDR_CTRL, 32'h0000_0808);
    i_src.convert({1'b1, 1'b0, 12'h7FF}, n);
    `CHK(irq, 1'b1)
    `CHK(range_flag, 1'b0)
    rd_chk(ADDR_ISTAT, 32'h0000_0005);
    fork
      i_src.convert({1'b0, 1'b0, 12'h0AA}, n);
      begin
        repeat (10) @(posedge sys_clk_i);
        rd_chk(ADDR_DATA, 32'h0000_0055);
      end
    join
    `CHK(n, CONV_CYCLES + 1)
    rd_chk(ADDR_CTRL, 32'h0000_0808);
    wr(ADDR_CTRL, 32'h0000_0048);
    rd_chk(ADDR_CTRL, 32'h0000_0018);
    rd_chk(ADDR_DATA, 32'h0000_0000);
    `CHK(alert_n, 1'b1)
    $display("test full done");
  endtask : t_full

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_level();
    t_range();
    t_full();
    end_of_test();
  end
endmodule : adc_fifo_host_interface_test
